// file: shared/csc_defs.svh
// constants for the charger status/control register and its serial slave port
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

`define CSC_SLAVE_ADDR 7'h6B
`define CSC_ADDR_STATUS 8'h00
`define CSC_UNMAPPED_READ 8'hFF
`define CSC_BIT_RESTART 7
`define CSC_BIT_HOST 7
`define CSC_BIT_STAT_EN 6
`define CSC_STAT_EN_RESET 1'h1
`define CSC_BOOST_RESET 1'h0
`define CSC_RD_HOLD_RESET 8'hFF
`define CSC_BITS_PER_BYTE 4'h8
`define CSC_LAST_TX_BIT 4'h7
`define CSC_SYNC_STAGES 2

`endif

// file: shared/csc_pkg.sv
// types shared by the charger status/control register block
package csc_pkg;

  typedef enum logic [1:0] {
    CSC_CS_READY = 2'b00,
    CSC_CS_CHARGING = 2'b01,
    CSC_CS_DONE = 2'b10,
    CSC_CS_FAULT = 2'b11
  } csc_charge_state_e;

  typedef enum logic [2:0] {
    CSC_CF_NORMAL = 3'b000,
    CSC_CF_IN_OVERVOLT = 3'b001,
    CSC_CF_SLEEP = 3'b010,
    CSC_CF_POOR_INPUT = 3'b011,
    CSC_CF_OUT_OVERVOLT = 3'b100,
    CSC_CF_THERMAL = 3'b101,
    CSC_CF_TIMER = 3'b110,
    CSC_CF_NO_BATTERY = 3'b111
  } csc_chg_fault_e;

  typedef enum logic [2:0] {
    CSC_BF_NORMAL = 3'b000,
    CSC_BF_BUS_OVERVOLT = 3'b001,
    CSC_BF_OVERLOAD = 3'b010,
    CSC_BF_BATT_LOW = 3'b011,
    CSC_BF_BATT_OVERVOLT = 3'b100,
    CSC_BF_THERMAL = 3'b101,
    CSC_BF_TIMER = 3'b110,
    CSC_BF_UNUSED = 3'b111
  } csc_bst_fault_e;

  typedef enum logic [3:0] {
    CSC_LS_IDLE = 4'b0000,
    CSC_LS_DEV_ADDR = 4'b0001,
    CSC_LS_DEV_ACK = 4'b0010,
    CSC_LS_REG_ADDR = 4'b0011,
    CSC_LS_REG_ACK = 4'b0100,
    CSC_LS_WR_DATA = 4'b0101,
    CSC_LS_WR_ACK = 4'b0110,
    CSC_LS_RD_DATA = 4'b0111,
    CSC_LS_RD_ACK = 4'b1000
  } csc_link_state_e;

  // live state from the charger core, same clock as mclk
  typedef struct packed {
    csc_charge_state_e charge_state;
    logic boost;
    logic [2:0] fault;
    logic stat_drive;
  } csc_chg_in_s;

  typedef struct packed {
    logic host_level;
    logic stat_en;
    csc_charge_state_e charge_state;
    logic boost;
    logic [2:0] fault;
  } csc_status_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } csc_wr_s;

endpackage : csc_pkg

// file: logic/csc_sync.sv
// multi-bit two-stage level synchroniser
`timescale 1ns/1ps
module csc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // meta_reg feeds q and nothing else
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : csc_sync

// file: logic/csc_event_xfer.sv
// toggle-based event crossing carrying a word held stable by the source
`timescale 1ns/1ps
module csc_event_xfer #(
  parameter int WIDTH = 8
) (
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_send,
  input wire logic [WIDTH-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic dst_valid,
  output logic [WIDTH-1:0] dst_data
);
  logic tgl_reg;
  logic [WIDTH-1:0] hold_reg;
  logic tgl_s;
  logic seen_reg;

  // limitation: a second send before the first lands can cancel its toggle, so neither event is seen
  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      tgl_reg <= 1'h0;
      hold_reg <= '0;
    end else if (src_send) begin
      tgl_reg <= ~tgl_reg;
      hold_reg <= src_data;
    end
  end

  csc_sync #(.WIDTH(1), .RST_VAL(1'h0)) u_tgl_sync (
    .clk(dst_clk),
    .rst_n(dst_rst_n),
    .d(tgl_reg),
    .q(tgl_s)
  );

  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      seen_reg <= 1'h0;
      dst_valid <= 1'h0;
      dst_data <= '0;
    end else begin
      seen_reg <= tgl_s;
      dst_valid <= tgl_s ^ seen_reg;
      if (tgl_s ^ seen_reg) begin
        dst_data <= hold_reg;
      end
    end
  end
endmodule : csc_event_xfer

// file: logic/csc_status_ctrl.sv
// status/control register at address 00 with its serial slave port on the link clock
`timescale 1ns/1ps
`include "csc_defs.svh"
module csc_status_ctrl (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic host_detect_pin,
  input wire csc_pkg::csc_chg_in_s chg_in,
  output logic safety_timer_restart,
  output logic status_indicator,
  output logic overvoltage_fault
);

  function automatic logic is_status_addr(input logic [7:0] addr);
    is_status_addr = (addr == `CSC_ADDR_STATUS);
  endfunction : is_status_addr

  // ---------------- link domain ----------------
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_q_reg;
  logic sda_q_reg;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  csc_pkg::csc_link_state_e st_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] reg_addr_reg;
  logic [7:0] wr_data_reg;
  logic rw_reg;
  logic nack_reg;
  logic [7:0] rd_hold_reg;
  logic wr_send;
  logic rq_send;
  logic rs_valid;
  logic [7:0] rs_data;

  csc_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk(link_clk),
    .rst_n(reset_n),
    .d({scl_in, sda_in}),
    .q(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign start_c = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign stop_c = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  assign scl_rise = scl_s & ~scl_q_reg;
  assign scl_fall = ~scl_s & scl_q_reg;
  assign wr_send = (st_reg == csc_pkg::CSC_LS_WR_ACK) && scl_fall;
  assign rq_send = (st_reg == csc_pkg::CSC_LS_REG_ACK) && scl_fall;
  assign sda_out = 1'h0;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  // read data waits here; a read with no register address yet returns FFh
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_hold_reg <= `CSC_RD_HOLD_RESET;
    end else if (rs_valid) begin
      rd_hold_reg <= rs_data;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= csc_pkg::CSC_LS_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      reg_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      rw_reg <= 1'h0;
      nack_reg <= 1'h0;
      sda_oe_n <= 1'h1;
    end else if (start_c) begin
      // a repeated start also lands here, so a read may follow an address write
      st_reg <= csc_pkg::CSC_LS_DEV_ADDR;
      cnt_reg <= 4'h0;
      sda_oe_n <= 1'h1;
    end else if (stop_c) begin
      st_reg <= csc_pkg::CSC_LS_IDLE;
      sda_oe_n <= 1'h1;
    end else begin
      case (st_reg)
        csc_pkg::CSC_LS_DEV_ADDR, csc_pkg::CSC_LS_REG_ADDR, csc_pkg::CSC_LS_WR_DATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == `CSC_BITS_PER_BYTE) begin
            cnt_reg <= 4'h0;
            if (st_reg == csc_pkg::CSC_LS_DEV_ADDR) begin
              if (shift_reg[7:1] == `CSC_SLAVE_ADDR) begin
                st_reg <= csc_pkg::CSC_LS_DEV_ACK;
                rw_reg <= shift_reg[0];
                sda_oe_n <= 1'h0;
              end else begin
                st_reg <= csc_pkg::CSC_LS_IDLE;
              end
            end else if (st_reg == csc_pkg::CSC_LS_REG_ADDR) begin
              st_reg <= csc_pkg::CSC_LS_REG_ACK;
              reg_addr_reg <= shift_reg;
              sda_oe_n <= 1'h0;
            end else begin
              st_reg <= csc_pkg::CSC_LS_WR_ACK;
              wr_data_reg <= shift_reg;
              sda_oe_n <= 1'h0;
            end
          end
        end
        csc_pkg::CSC_LS_DEV_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              st_reg <= csc_pkg::CSC_LS_RD_DATA;
              tx_reg <= rd_hold_reg;
              sda_oe_n <= rd_hold_reg[7];
            end else begin
              st_reg <= csc_pkg::CSC_LS_REG_ADDR;
              sda_oe_n <= 1'h1;
            end
          end
        end
        csc_pkg::CSC_LS_REG_ACK: begin
          if (scl_fall) begin
            st_reg <= csc_pkg::CSC_LS_WR_DATA;
            sda_oe_n <= 1'h1;
          end
        end
        csc_pkg::CSC_LS_WR_ACK: begin
          // further updates need only a register address and a data byte
          if (scl_fall) begin
            st_reg <= csc_pkg::CSC_LS_REG_ADDR;
            sda_oe_n <= 1'h1;
          end
        end
        csc_pkg::CSC_LS_RD_DATA: begin
          if (scl_fall) begin
            if (cnt_reg == `CSC_LAST_TX_BIT) begin
              st_reg <= csc_pkg::CSC_LS_RD_ACK;
              cnt_reg <= 4'h0;
              sda_oe_n <= 1'h1;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'h0};
              sda_oe_n <= tx_reg[6];
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        csc_pkg::CSC_LS_RD_ACK: begin
          if (scl_rise) begin
            nack_reg <= sda_s;
          end else if (scl_fall) begin
            if (nack_reg) begin
              st_reg <= csc_pkg::CSC_LS_IDLE;
            end else begin
              st_reg <= csc_pkg::CSC_LS_RD_DATA;
              tx_reg <= rd_hold_reg;
              sda_oe_n <= rd_hold_reg[7];
            end
          end
        end
        default: begin
          st_reg <= csc_pkg::CSC_LS_IDLE;
          sda_oe_n <= 1'h1;
        end
      endcase
    end
  end

  // ---------------- crossings ----------------
  logic wr_valid;
  csc_pkg::csc_wr_s wr_q;
  logic rq_valid;
  logic [7:0] rq_addr;
  logic rs_send_reg;
  logic [7:0] rs_data_reg;

  csc_event_xfer #(.WIDTH(16)) u_wr_xfer (
    .src_clk(link_clk),
    .src_rst_n(reset_n),
    .src_send(wr_send),
    .src_data({reg_addr_reg, wr_data_reg}),
    .dst_clk(mclk),
    .dst_rst_n(reset_n),
    .dst_valid(wr_valid),
    .dst_data(wr_q)
  );

  csc_event_xfer #(.WIDTH(8)) u_rq_xfer (
    .src_clk(link_clk),
    .src_rst_n(reset_n),
    .src_send(rq_send),
    .src_data(shift_reg),
    .dst_clk(mclk),
    .dst_rst_n(reset_n),
    .dst_valid(rq_valid),
    .dst_data(rq_addr)
  );

  csc_event_xfer #(.WIDTH(8)) u_rs_xfer (
    .src_clk(mclk),
    .src_rst_n(reset_n),
    .src_send(rs_send_reg),
    .src_data(rs_data_reg),
    .dst_clk(link_clk),
    .dst_rst_n(reset_n),
    .dst_valid(rs_valid),
    .dst_data(rs_data)
  );

  // ---------------- register domain ----------------
  logic host_s;
  logic stat_en_reg;
  logic boost_reg;
  logic wr_fire;
  csc_pkg::csc_status_s status;

  csc_sync #(.WIDTH(1), .RST_VAL(1'h0)) u_host_sync (
    .clk(mclk),
    .rst_n(reset_n),
    .d(host_detect_pin),
    .q(host_s)
  );

  assign wr_fire = wr_valid && is_status_addr(wr_q.addr);
  // bits 5:0 come from core state (bit 3 through boost_reg), so a write cannot reach them
  assign status = '{host_level: host_s, stat_en: stat_en_reg, charge_state: chg_in.charge_state,
                    boost: boost_reg, fault: chg_in.fault};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stat_en_reg <= `CSC_STAT_EN_RESET;
    end else if (wr_fire) begin
      stat_en_reg <= wr_q.data[`CSC_BIT_STAT_EN];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      boost_reg <= `CSC_BOOST_RESET;
    end else begin
      boost_reg <= chg_in.boost;
    end
  end

  // one-cycle restart strobe; writing 0 leaves the timer alone
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      safety_timer_restart <= 1'h0;
    end else begin
      safety_timer_restart <= wr_fire && wr_q.data[`CSC_BIT_RESTART];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_indicator <= 1'h0;
      overvoltage_fault <= 1'h0;
    end else begin
      status_indicator <= stat_en_reg & chg_in.stat_drive;
      overvoltage_fault <= (chg_in.fault == csc_pkg::CSC_CF_IN_OVERVOLT);
    end
  end

  // snapshot taken when the register address arrives, ahead of the read phase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rs_send_reg <= 1'h0;
      rs_data_reg <= `CSC_RD_HOLD_RESET;
    end else begin
      rs_send_reg <= rq_valid;
      if (rq_valid) begin
        rs_data_reg <= is_status_addr(rq_addr) ? status : `CSC_UNMAPPED_READ;
      end
    end
  end

  // ---------------- checks ----------------
  property p_restart_pulse;
    @(posedge mclk) disable iff (!reset_n)
      wr_fire && wr_q.data[7] |=> safety_timer_restart ##1 !safety_timer_restart;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart strobe wrong");

  property p_restart_zero;
    @(posedge mclk) disable iff (!reset_n)
      !(wr_fire && wr_q.data[7]) |=> !safety_timer_restart;
  endproperty
  a_restart_zero: assert property (p_restart_zero) else $error("restart without write of 1");

  property p_host_bit;
    @(posedge mclk) disable iff (!reset_n)
      rq_valid && rq_addr == 8'h00 |=> rs_data_reg[7] == $past(host_s);
  endproperty
  a_host_bit: assert property (p_host_bit) else $error("host level bit wrong");

  property p_stat_en_write;
    @(posedge mclk) disable iff (!reset_n)
      wr_fire |=> stat_en_reg == $past(wr_q.data[6]) ##1 status_indicator == (stat_en_reg & $past(chg_in.stat_drive));
  endproperty
  a_stat_en_write: assert property (p_stat_en_write) else $error("indicator enable wrong");

  property p_charge_state;
    @(posedge mclk) disable iff (!reset_n)
      rq_valid && rq_addr == 8'h00 |=> rs_data_reg[5:4] == $past(chg_in.charge_state) && rs_send_reg;
  endproperty
  a_charge_state: assert property (p_charge_state) else $error("charge state bits wrong");

  property p_boost;
    @(posedge mclk) disable iff (!reset_n)
      rq_valid && rq_addr == 8'h00 |=> rs_data_reg[3] == $past(boost_reg);
  endproperty
  a_boost: assert property (p_boost) else $error("step-up bit wrong");

  property p_fault_charge;
    @(posedge mclk) disable iff (!reset_n)
      rq_valid && rq_addr == 8'h00 && !boost_reg |=> rs_data_reg[2:0] == $past(chg_in.fault) && !rs_data_reg[3];
  endproperty
  a_fault_charge: assert property (p_fault_charge) else $error("charge fault code wrong");

  property p_fault_boost;
    @(posedge mclk) disable iff (!reset_n)
      rq_valid && rq_addr == 8'h00 && boost_reg |=> rs_data_reg[2:0] == $past(chg_in.fault) && rs_data_reg[3];
  endproperty
  a_fault_boost: assert property (p_fault_boost) else $error("step-up fault code wrong");

  property p_reset_vals;
    @(posedge mclk) disable iff (!reset_n)
      $rose(reset_n) |-> stat_en_reg && !boost_reg && !safety_timer_restart;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  // a write must leave the reported core state exactly as the core drives it
  property p_ro_ignored;
    @(posedge mclk) disable iff (!reset_n)
      wr_fire |=> status[5:0] == {chg_in.charge_state, $past(chg_in.boost), chg_in.fault};
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("read-only bits disturbed");

  property p_addr_nomatch;
    @(posedge link_clk) disable iff (!reset_n)
      st_reg == csc_pkg::CSC_LS_DEV_ADDR && scl_fall && cnt_reg == `CSC_BITS_PER_BYTE
      && shift_reg[7:1] != `CSC_SLAVE_ADDR |=> st_reg == csc_pkg::CSC_LS_IDLE && sda_oe_n;
  endproperty
  a_addr_nomatch: assert property (p_addr_nomatch) else $error("answered a foreign address");

  property p_write_at_ack_fall;
    @(posedge link_clk) disable iff (!reset_n)
      wr_send |-> $past(st_reg) == csc_pkg::CSC_LS_WR_ACK ##1 st_reg == csc_pkg::CSC_LS_REG_ADDR && sda_oe_n;
  endproperty
  a_write_at_ack_fall: assert property (p_write_at_ack_fall) else $error("write not at ack fall");

  property p_unmapped;
    @(posedge mclk) disable iff (!reset_n)
      rq_valid && rq_addr != 8'h00 |=> rs_data_reg == 8'hFF && rs_send_reg;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not FFh");

  c_restart: cover property (@(posedge mclk) disable iff (!reset_n) safety_timer_restart);
  c_status_read: cover property (@(posedge mclk) disable iff (!reset_n) rq_valid && rq_addr == 8'h00);
  c_unmapped_read: cover property (@(posedge mclk) disable iff (!reset_n) rq_valid && rq_addr != 8'h00);
  c_read_byte_done: cover property (@(posedge link_clk) disable iff (!reset_n) st_reg == csc_pkg::CSC_LS_RD_ACK);

endmodule : csc_status_ctrl

// file: bench/csc_host_model.sv
// bit-level serial bus master standing in for the host processor
`timescale 1ns/1ps
module csc_host_model #(
  parameter int QTR = 4
) (
  input wire logic mclk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  // scl stays driven high and sda stands released outside frames; the pull-up holds sda high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // also a repeated start when entered with scl low
  task automatic start_cond();
    tick(1);
    sda_low <= 1'b0;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    sda_low <= 1'b1;
    tick(QTR);
    scl <= 1'b0;
    tick(QTR);
  endtask : start_cond

  // data changes only while scl is low and is sampled mid-high
  task automatic put_bit(input logic b, output logic seen);
    sda_low <= ~b;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    seen = sda_wire;
    tick(QTR);
    scl <= 1'b0;
    tick(QTR);
  endtask : put_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  task automatic recv_byte(input logic ack_it, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(~ack_it, s);
  endtask : recv_byte

  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    sda_low <= 1'b0;
    tick(2 * QTR);
  endtask : stop_cond
endmodule : csc_host_model

// file: bench/testbench.sv
// self-checking bench for the charger status/control register
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] SLV = 7'h6B;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic host_detect_pin = 1'b0;
  csc_pkg::csc_chg_in_s chg_in = '0;
  logic scl;
  logic sda_low;
  logic sda_wire;
  logic sda_out;
  logic sda_oe_n;
  logic safety_timer_restart;
  logic status_indicator;
  logic overvoltage_fault;
  int err_count = 0;
  int compares = 0;
  int pulses = 0;
  logic en_m = 1'b1;

  always #12.5 mclk = ~mclk;
  // 12 ns link clock, edges drift against mclk
  always #6 link_clk = ~link_clk;

  // open-drain wire: low if either party pulls, else the pull-up
  assign sda_wire = (sda_low || (sda_oe_n === 1'b0 && sda_out === 1'b0)) ? 1'b0 : 1'b1;

  always @(posedge mclk) if (safety_timer_restart === 1'b1) pulses <= pulses + 1;

  csc_status_ctrl uut (
    .mclk(mclk),
    .reset_n(reset_n),
    .link_clk(link_clk),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .host_detect_pin(host_detect_pin),
    .chg_in(chg_in),
    .safety_timer_restart(safety_timer_restart),
    .status_indicator(status_indicator),
    .overvoltage_fault(overvoltage_fault)
  );

  csc_host_model host (
    .mclk(mclk),
    .sda_wire(sda_wire),
    .scl(scl),
    .sda_low(sda_low)
  );

  task automatic complete_run();
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] exp_status(input logic h, input logic en, input csc_pkg::csc_chg_in_s c);
    return {h, en, c.charge_state, c.boost, c.fault};
  endfunction : exp_status

  task automatic set_in(input logic h, input csc_pkg::csc_chg_in_s c);
    @(posedge mclk);
    host_detect_pin <= h;
    chg_in <= c;
    repeat (6) @(posedge mclk);
  endtask : set_in

  task automatic addr_phase(input logic [7:0] ra);
    logic a;
    host.start_cond();
    host.send_byte({SLV, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    host.send_byte(ra, a);
    chk({7'h00, a}, 8'h01);
  endtask : addr_phase

  // a late or doubled restart pulse shows up in the count
  task automatic settle(input int base, input int n);
    for (int i = 0; i < 40 && pulses - base < n; i++) @(posedge mclk);
    repeat (8) @(negedge mclk);
    chk(8'(pulses - base), 8'(n));
    chk({7'h00, status_indicator}, {7'h00, en_m & chg_in.stat_drive});
  endtask : settle

  task automatic write_reg(input logic [7:0] ra, input logic [7:0] d);
    logic a;
    int base;
    base = pulses;
    addr_phase(ra);
    host.send_byte(d, a);
    chk({7'h00, a}, 8'h01);
    host.stop_cond();
    if (ra == 8'h00) en_m = d[6];
    settle(base, (ra == 8'h00) ? int'(d[7]) : 0);
  endtask : write_reg

  // gap before the read phase lets the snapshot cross both ways
  task automatic read_reg(input logic [7:0] ra, input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    addr_phase(ra);
    host.tick(24);
    host.start_cond();
    host.send_byte({SLV, 1'b1}, a);
    chk({7'h00, a}, 8'h01);
    host.recv_byte(1'b1, d);
    chk(d, exp);
    // master ack asks for the same snapshot again
    host.recv_byte(1'b0, d);
    host.stop_cond();
    chk(d, exp);
  endtask : read_reg

  initial begin
    repeat (90000) @(posedge mclk);
    err_count++;
    complete_run();
  end

  initial begin
    csc_pkg::csc_chg_in_s c;
    logic [7:0] seq [3];
    logic a;
    int base;
    void'($urandom(50));
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({7'h00, status_indicator}, 8'h00);
    @(posedge mclk);
    reset_n <= 1'b1;
    c = '0;
    c.stat_drive = 1'b1;
    set_in(1'b1, c);
    @(negedge mclk);
    chk({7'h00, status_indicator}, 8'h01);
    read_reg(8'h00, exp_status(1'b1, 1'b1, c));
    write_reg(8'h00, 8'hFF);
    write_reg(8'h00, 8'h00);
    read_reg(8'h00, exp_status(1'b1, 1'b0, c));
    // foreign address must not be acknowledged
    host.start_cond();
    host.send_byte({7'h6A, 1'b0}, a);
    chk({7'h00, a}, 8'h00);
    host.stop_cond();
    write_reg(8'h03, 8'hFF);
    read_reg(8'h03, 8'hFF);
    read_reg(8'h05, 8'hFF);
    // two updates in one frame, address and data only
    base = pulses;
    seq = '{8'h80, 8'h00, 8'hC0};
    addr_phase(8'h00);
    foreach (seq[k]) begin
      host.send_byte(seq[k], a);
      chk({7'h00, a}, 8'h01);
    end
    host.stop_cond();
    en_m = 1'b1;
    settle(base, 2);
    for (int i = 0; i < 16; i++) begin
      c = 7'($urandom);
      c.boost = i[3];
      c.fault = i[2:0];
      set_in(1'($urandom), c);
      write_reg(8'h00, 8'($urandom));
      chk({7'h00, overvoltage_fault}, {7'h00, c.fault == 3'h1});
      read_reg(8'h00, exp_status(host_detect_pin, en_m, c));
    end
    complete_run();
  end
endmodule : testbench
